// File: shared/cfd_pkg.sv
// Package for the configuration word bank and its decoded settings.
// Assumes a single 125 MHz clock and table access from core or programmer.
package cfd_pkg;
  // Configuration space addressing
  localparam logic [23:0] CFD_SPACE_BASE = 24'h800000;
  localparam logic [23:0] CFD_OFS_BOOT = 24'hF80000;
  localparam logic [23:0] CFD_OFS_GEN = 24'hF80004;
  localparam logic [23:0] CFD_OFS_OSCSEL = 24'hF80006;
  localparam logic [23:0] CFD_OFS_OSC = 24'hF80008;
  localparam logic [23:0] CFD_OFS_WDT = 24'hF8000A;
  localparam logic [23:0] CFD_OFS_RST = 24'hF8000C;
  localparam logic [23:0] CFD_OFS_DBG = 24'hF8000E;
  localparam int CFD_NUM_WORDS = 7;
  // Word indices in the bank
  localparam logic [2:0] CFD_IDX_BOOT = 3'h0;
  localparam logic [2:0] CFD_IDX_GEN = 3'h1;
  localparam logic [2:0] CFD_IDX_OSCSEL = 3'h2;
  localparam logic [2:0] CFD_IDX_OSC = 3'h3;
  localparam logic [2:0] CFD_IDX_WDT = 3'h4;
  localparam logic [2:0] CFD_IDX_RST = 3'h5;
  localparam logic [2:0] CFD_IDX_DBG = 3'h6;
  // Implemented bit masks per word
  localparam logic [7:0] CFD_MASK_BOOT = 8'h0F;
  localparam logic [7:0] CFD_MASK_GEN = 8'h03;
  localparam logic [7:0] CFD_MASK_OSCSEL = 8'hE7;
  localparam logic [7:0] CFD_MASK_OSC = 8'hFF;
  localparam logic [7:0] CFD_MASK_WDT = 8'hFF;
  localparam logic [7:0] CFD_MASK_RST = 8'hFB;
  localparam logic [7:0] CFD_MASK_DBG = 8'h83;
  // Unimplemented bits that read as one
  localparam logic [7:0] CFD_ONES_DBG = 8'h60;
  // Erased (unprogrammed) word value
  localparam logic [7:0] CFD_ERASED = 8'hFF;
  // Field positions
  localparam int CFD_BOOT_WP_BIT = 0;
  localparam int CFD_BOOT_SEL_LSB = 1;
  localparam int CFD_GEN_WP_BIT = 0;
  localparam int CFD_GEN_CP_BIT = 1;
  localparam int CFD_TWO_SPEED_STARTUP_EN_BIT = 7;
  localparam int CFD_LOW_POWER_RC_OSC_BIT = 6;
  localparam int CFD_SOSRC_BIT = 5;
  localparam int CFD_NOSC_LSB = 0;
  localparam int CFD_CKSM_LSB = 6;
  localparam int CFD_SOSPWR_BIT = 5;
  localparam int CFD_PFREQ_LSB = 3;
  localparam int CFD_CLOCK_OUTPUT_BIT = 2;
  localparam int CFD_PMD_LSB = 0;
  localparam int CFD_WEN_HI_BIT = 7;
  localparam int CFD_WIN_BIT = 6;
  localparam int CFD_WEN_LO_BIT = 5;
  localparam int CFD_WPSA_BIT = 4;
  localparam int CFD_WPS_LSB = 0;
  localparam int CFD_XRST_BIT = 7;
  localparam int CFD_BROWNOUT_THRESHOLD_SEL_LSB = 5;
  localparam int CFD_I2C_BIT = 4;
  localparam int CFD_PWRT_BIT = 3;
  localparam int CFD_BROWNOUT_ENABLE_SEL_LSB = 0;
  localparam int CFD_DEBUG_BIT = 7;
  localparam int CFD_ICS_LSB = 0;
  // Boot segment bounds
  localparam logic [15:0] CFD_BOOT_START = 16'h0200;
  localparam logic [15:0] CFD_BOOT_END_SMALL = 16'h0AFE;
  localparam logic [15:0] CFD_BOOT_END_LARGE = 16'h15FE;
  // Watchdog prescale ratios
  localparam logic [7:0] CFD_WDT_PRE_HI = 8'h80;
  localparam logic [7:0] CFD_WDT_PRE_LO = 8'h20;

  typedef enum logic [1:0] {CFD_SEC_NONE, CFD_SEC_STD, CFD_SEC_HIGH, CFD_SEC_RSVD}
    cfd_sec_type;
  typedef enum logic [2:0] {
    CFD_OSC_FRC, CFD_OSC_FRCPLL, CFD_OSC_PRI, CFD_OSC_PRIPLL,
    CFD_OSC_SEC, CFD_OSC_LOW_POWER_RC_OSC, CFD_OSC_LPFRCDIV, CFD_OSC_FRCDIV
  } cfd_osc_type;
  typedef enum logic [1:0] {CFD_WDT_OFF, CFD_WDT_ACTIVE, CFD_WDT_SOFT, CFD_WDT_ON}
    cfd_wdt_mode_type;

  // Table access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [23:0] addr;
    logic [7:0] data;
  } cfd_req_type;

  // Decoded settings delivered to consumers
  typedef struct packed {
    cfd_sec_type boot_sec;
    logic boot_present;
    logic [15:0] boot_end;
    logic boot_write_protect;
    logic general_write_protect;
    logic general_code_protect;
    logic two_speed_startup_en;
    logic low_power_rc_power_sel;
    logic secondary_osc_source_sel;
    cfd_osc_type initial_osc_sel;
    logic clock_switch_en;
    logic fail_safe_en;
    logic secondary_osc_power_sel;
    logic [1:0] primary_osc_range;
    logic primary_range_rsvd;
    logic clock_output;
    logic [1:0] primary_osc_mode;
    cfd_wdt_mode_type watchdog_mode;
    logic window_mode;
    logic [7:0] watchdog_prescale;
    logic [3:0] watchdog_postscale_sel;
    logic ext_reset_pin_en;
    logic [1:0] brownout_threshold_sel;
    logic low_power_brownout;
    logic [1:0] brownout_enable_sel;
    logic alt_i2c_pin_map;
    logic powerup_timer_en;
    logic debug_en;
    logic [1:0] debug_pin_pair;
  } cfd_cfg_type;
endpackage

// File: rtl/cfd_decoder.sv
// Configuration word bank with table read/write access and reset-time decode.
// Assumes table requests are one-cycle pulses synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

module cfd_decoder (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire cfd_pkg::cfd_req_type req_i,
  input wire logic bulk_erase_i,
  input wire logic hv_entry_i,
  input wire logic soft_watchdog_wr_i,
  input wire logic soft_watchdog_val_i,
  input wire logic soft_brownout_en_i,
  input wire logic sleep_i,
  input wire logic watchdog_clear_op_i,
  input wire logic watchdog_early_i,
  input wire logic boot_seg_wr_i,
  input wire logic general_seg_wr_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic wr_refused_o,
  output cfd_pkg::cfd_cfg_type cfg_o,
  output logic watchdog_run_o,
  output logic brownout_run_o,
  output logic soft_watchdog_en_o,
  output logic watchdog_clear_reset_o,
  output logic boot_seg_wr_ok_o,
  output logic general_seg_wr_ok_o
);
  import cfd_pkg::*;

  logic [7:0] word_reg [CFD_NUM_WORDS];
  logic [7:0] mask_tab [CFD_NUM_WORDS];
  logic [2:0] idx;
  logic hit;
  logic [7:0] wmask;
  logic prot_any_clear;
  cfd_cfg_type dec;
  logic wdt_sw_reg;

  // Implemented-bit masks, one per word
  // Bits outside a mask never change on a write and read back as zero,
  // except the two debugger bits that are forced to one on the read path.
  // Keeping masks as a table lets the read and write paths share one index.
  assign mask_tab[0] = CFD_MASK_BOOT;
  assign mask_tab[1] = CFD_MASK_GEN;
  assign mask_tab[2] = CFD_MASK_OSCSEL;
  assign mask_tab[3] = CFD_MASK_OSC;
  assign mask_tab[4] = CFD_MASK_WDT;
  assign mask_tab[5] = CFD_MASK_RST;
  assign mask_tab[6] = CFD_MASK_DBG;

  // Address decode into the configuration space only
  always_comb begin
    hit = 1'b1;
    idx = CFD_IDX_BOOT;
    unique case (req_i.addr)
      CFD_OFS_BOOT: idx = CFD_IDX_BOOT;
      CFD_OFS_GEN: idx = CFD_IDX_GEN;
      CFD_OFS_OSCSEL: idx = CFD_IDX_OSCSEL;
      CFD_OFS_OSC: idx = CFD_IDX_OSC;
      CFD_OFS_WDT: idx = CFD_IDX_WDT;
      CFD_OFS_RST: idx = CFD_IDX_RST;
      CFD_OFS_DBG: idx = CFD_IDX_DBG;
      default: hit = 1'b0;
    endcase
  end

  // Protection group already partly programmed blocks further clearing of it
  assign prot_any_clear = (word_reg[CFD_IDX_BOOT][3:0] != 4'hF) ||
                          (word_reg[CFD_IDX_GEN][1:0] != 2'h3);

  // Per-write mask of bits that may change
  always_comb begin
    wmask = mask_tab[idx];
    if (idx == CFD_IDX_RST && !hv_entry_i) begin
      wmask[CFD_XRST_BIT] = 1'b0;
    end
    if ((idx == CFD_IDX_BOOT || idx == CFD_IDX_GEN) && prot_any_clear) begin
      wmask = 8'h00;
    end
  end

  // Bank storage: programming only clears bits, bulk erase sets all
  genvar g;
  generate
    for (g = 0; g < CFD_NUM_WORDS; g++) begin : g_word
      always_ff @(posedge clk_i) begin
        if (bulk_erase_i) begin
          word_reg[g] <= CFD_ERASED;
        end else if (req_i.wr && hit && idx == 3'(g)) begin
          word_reg[g] <= word_reg[g] & (req_i.data | ~wmask);
        end
      end
    end
  endgenerate

  // Table read path; unimplemented bits read zero except debugger ones
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
      wr_refused_o <= 1'b0;
    end else begin
      rd_valid_o <= req_i.rd;
      wr_refused_o <= req_i.wr && (!hit || (wmask == 8'h00));
      if (req_i.rd && hit) begin
        rd_data_o <= (word_reg[idx] & mask_tab[idx]) |
                     ((idx == CFD_IDX_DBG) ? CFD_ONES_DBG : 8'h00);
      end else begin
        rd_data_o <= 8'h00;
      end
    end
  end

  // Field decode from the bank
  always_comb begin
    logic [7:0] b;
    logic [7:0] o;
    logic [7:0] w;
    logic [7:0] r;
    b = word_reg[CFD_IDX_BOOT];
    o = word_reg[CFD_IDX_OSC];
    w = word_reg[CFD_IDX_WDT];
    r = word_reg[CFD_IDX_RST];
    dec = '0;
    unique case (b[CFD_BOOT_SEL_LSB +: 3])
      3'h7: dec.boot_sec = CFD_SEC_NONE;
      3'h6, 3'h5: dec.boot_sec = CFD_SEC_STD;
      3'h2, 3'h1: dec.boot_sec = CFD_SEC_HIGH;
      default: dec.boot_sec = CFD_SEC_RSVD;
    endcase
    dec.boot_present = (dec.boot_sec == CFD_SEC_STD) || (dec.boot_sec == CFD_SEC_HIGH);
    dec.boot_end = (b[CFD_BOOT_SEL_LSB +: 3] == 3'h1) ? CFD_BOOT_END_LARGE
                                                      : CFD_BOOT_END_SMALL;
    dec.boot_write_protect = ~b[CFD_BOOT_WP_BIT];
    dec.general_write_protect = ~word_reg[CFD_IDX_GEN][CFD_GEN_WP_BIT];
    dec.general_code_protect = ~word_reg[CFD_IDX_GEN][CFD_GEN_CP_BIT];
    dec.two_speed_startup_en = word_reg[CFD_IDX_OSCSEL][CFD_TWO_SPEED_STARTUP_EN_BIT];
    dec.low_power_rc_power_sel = word_reg[CFD_IDX_OSCSEL][CFD_LOW_POWER_RC_OSC_BIT];
    dec.secondary_osc_source_sel = word_reg[CFD_IDX_OSCSEL][CFD_SOSRC_BIT];
    dec.initial_osc_sel = cfd_osc_type'(word_reg[CFD_IDX_OSCSEL][CFD_NOSC_LSB +: 3]);
    dec.clock_switch_en = ~o[CFD_CKSM_LSB + 1];
    dec.fail_safe_en = ~o[CFD_CKSM_LSB + 1] & ~o[CFD_CKSM_LSB];
    dec.secondary_osc_power_sel = o[CFD_SOSPWR_BIT];
    dec.primary_osc_range = o[CFD_PFREQ_LSB +: 2];
    dec.primary_range_rsvd = (o[CFD_PFREQ_LSB +: 2] == 2'h0);
    dec.primary_osc_mode = o[CFD_PMD_LSB +: 2];
    dec.clock_output = o[CFD_CLOCK_OUTPUT_BIT] &&
      (o[CFD_PMD_LSB +: 2] == 2'h3 || o[CFD_PMD_LSB +: 2] == 2'h0);
    dec.watchdog_mode = cfd_wdt_mode_type'({w[CFD_WEN_HI_BIT], w[CFD_WEN_LO_BIT]} == 2'h3 ?
      CFD_WDT_ON : {w[CFD_WEN_HI_BIT], w[CFD_WEN_LO_BIT]} == 2'h2 ? CFD_WDT_SOFT :
      {w[CFD_WEN_HI_BIT], w[CFD_WEN_LO_BIT]} == 2'h1 ? CFD_WDT_ACTIVE : CFD_WDT_OFF);
    dec.window_mode = ~w[CFD_WIN_BIT];
    dec.watchdog_prescale = w[CFD_WPSA_BIT] ? CFD_WDT_PRE_HI : CFD_WDT_PRE_LO;
    dec.watchdog_postscale_sel = w[CFD_WPS_LSB +: 4];
    dec.ext_reset_pin_en = r[CFD_XRST_BIT];
    dec.brownout_threshold_sel = r[CFD_BROWNOUT_THRESHOLD_SEL_LSB +: 2];
    dec.low_power_brownout = (r[CFD_BROWNOUT_THRESHOLD_SEL_LSB +: 2] == 2'h0);
    dec.alt_i2c_pin_map = ~r[CFD_I2C_BIT];
    dec.powerup_timer_en = r[CFD_PWRT_BIT];
    dec.brownout_enable_sel = r[CFD_BROWNOUT_ENABLE_SEL_LSB +: 2];
    dec.debug_en = ~word_reg[CFD_IDX_DBG][CFD_DEBUG_BIT];
    dec.debug_pin_pair = word_reg[CFD_IDX_DBG][CFD_ICS_LSB +: 2];
  end

  // Settings latch while reset is held, then stay frozen for consumers
  // Programming after release changes the bank only; consumers see it after
  // the next reset, so no setting can move under running clock or watchdog.
  // Reset must therefore last at least one edge after the bank is settled.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_o <= dec;
    end
  end

  // Software watchdog enable, cleared by every reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wdt_sw_reg <= 1'b0;
    end else if (soft_watchdog_wr_i) begin
      wdt_sw_reg <= soft_watchdog_val_i;
    end
  end

  // Run controls derived from frozen settings
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      watchdog_run_o <= 1'b0;
      brownout_run_o <= 1'b0;
      soft_watchdog_en_o <= 1'b0;
      watchdog_clear_reset_o <= 1'b0;
    end else begin
      soft_watchdog_en_o <= wdt_sw_reg;
      unique case (cfg_o.watchdog_mode)
        CFD_WDT_ON: watchdog_run_o <= 1'b1;
        CFD_WDT_SOFT: watchdog_run_o <= wdt_sw_reg;
        CFD_WDT_ACTIVE: watchdog_run_o <= ~sleep_i;
        CFD_WDT_OFF: watchdog_run_o <= 1'b0;
      endcase
      unique case (cfg_o.brownout_enable_sel)
        2'h3: brownout_run_o <= 1'b1;
        2'h2: brownout_run_o <= ~sleep_i;
        2'h1: brownout_run_o <= soft_brownout_en_i;
        2'h0: brownout_run_o <= 1'b0;
      endcase
      // Early clear only matters in window mode unless the watchdog is off or soft and disabled; sleep is ignored
      watchdog_clear_reset_o <= watchdog_clear_op_i && watchdog_early_i &&
        cfg_o.window_mode && (cfg_o.watchdog_mode != CFD_WDT_OFF) &&
        !(cfg_o.watchdog_mode == CFD_WDT_SOFT && !wdt_sw_reg);
    end
  end

  // Segment write gates from the frozen protect bits
  // Gates pass a one-cycle strobe only; refusal is silent toward the requester.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      boot_seg_wr_ok_o <= 1'b0;
      general_seg_wr_ok_o <= 1'b0;
    end else begin
      boot_seg_wr_ok_o <= boot_seg_wr_i && !cfg_o.boot_write_protect;
      general_seg_wr_ok_o <= general_seg_wr_i && !cfg_o.general_write_protect;
    end
  end
endmodule // cfd_decoder

`default_nettype wire

// File: test/cfd_properties.sv
// Checker on the configuration bank decoder ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cfd_checker
  import cfd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire cfd_pkg::cfd_req_type req_i,
  input wire logic watchdog_clear_op_i,
  input wire logic watchdog_early_i,
  input wire logic boot_seg_wr_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic wr_refused_o,
  input wire cfd_pkg::cfd_cfg_type cfg_o,
  input wire logic watchdog_run_o,
  input wire logic soft_watchdog_en_o,
  input wire logic watchdog_clear_reset_o,
  input wire logic boot_seg_wr_ok_o
);
  logic mapped;
  // Seven word addresses; everything else in the space is a hole
  assign mapped = req_i.addr inside {CFD_OFS_BOOT, CFD_OFS_GEN, CFD_OFS_OSCSEL, CFD_OFS_OSC,
    CFD_OFS_WDT, CFD_OFS_RST, CFD_OFS_DBG};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence stray_rd_s; req_i.rd && !mapped; endsequence
  sequence stray_wr_s; req_i.wr && !mapped; endsequence
  sequence early_clr_s;
    watchdog_clear_op_i && watchdog_early_i && cfg_o.window_mode &&
      cfg_o.watchdog_mode == CFD_WDT_ON;
  endsequence
  rd_answer_a: assert property (req_i.rd |=> rd_valid_o) else $error("read not answered");
  rd_origin_a: assert property (rd_valid_o |-> $past(req_i.rd)) else $error("stray read valid");
  stray_read_a: assert property (stray_rd_s |=> rd_data_o == 8'h00) else $error("hole read");
  stray_write_a: assert property (stray_wr_s |=> wr_refused_o) else $error("hole write");
  cfg_frozen_a: assert property ($past(rst_n_i) |-> $stable(cfg_o)) else $error("cfg moved");
  boot_guard_a: assert property (boot_seg_wr_i |=> boot_seg_wr_ok_o ==
    !$past(cfg_o.boot_write_protect)) else $error("boot write gate wrong");
  soft_clear_a: assert property ($rose(rst_n_i) |-> !soft_watchdog_en_o)
    else $error("soft enable kept");
  wd_run_a: assert property (cfg_o.watchdog_mode == CFD_WDT_ON |=> watchdog_run_o)
    else $error("watchdog not running");
  clr_off_a: assert property (watchdog_clear_op_i && cfg_o.watchdog_mode == CFD_WDT_OFF
    |=> !watchdog_clear_reset_o) else $error("clear reset while off");
  early_clr_a: assert property (early_clr_s |=> watchdog_clear_reset_o)
    else $error("early clear missed");
endmodule // cfd_checker
bind cfd_decoder cfd_checker cfd_checker_inst (.clk_i, .rst_n_i, .req_i, .watchdog_clear_op_i,
  .watchdog_early_i, .boot_seg_wr_i, .rd_data_o, .rd_valid_o, .wr_refused_o, .cfg_o,
  .watchdog_run_o, .soft_watchdog_en_o, .watchdog_clear_reset_o, .boot_seg_wr_ok_o);
`default_nettype wire

// File: test/cfd_host_model.sv
// Table access master standing in for the core or serial programmer.
// Assumes the bank answers one cycle after a request is taken.
`timescale 1ns/1ps
`default_nettype none
module cfd_host_model
  import cfd_pkg::*;
(
  input wire logic clk_i,
  output cfd_pkg::cfd_req_type req_o,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  input wire logic wr_refused_i
);
  initial req_o = '0;
  // One access; idle bus shows inverted values so stale data never looks valid
  task automatic xfer(input logic w, input logic [23:0] a, input logic [7:0] d, input int gap,
    output logic [7:0] q, output logic v, output logic r);
    repeat (gap) @(negedge clk_i);
    @(negedge clk_i);
    req_o <= '{rd: !w, wr: w, addr: a, data: d};
    @(negedge clk_i);
    q = rd_data_i;
    v = rd_valid_i;
    r = wr_refused_i;
    req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, data: ~d};
  endtask
endmodule // cfd_host_model
`default_nettype wire

// File: test/cfd_decoder_tb.sv
// Self-checking bench for the configuration bank and its decode.
// Assumes the host model issues table accesses; side inputs driven here.
`timescale 1ns/1ps
`default_nettype none
module cfd_decoder_tb;
  import cfd_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, bulk_erase_i = 1'b1, hv_entry_i = 1'b0, sleep_i = 1'b0;
  logic soft_watchdog_wr_i = 1'b0, soft_watchdog_val_i = 1'b0, soft_brownout_en_i = 1'b0;
  logic watchdog_clear_op_i = 1'b0, watchdog_early_i = 1'b0;
  logic boot_seg_wr_i = 1'b0, general_seg_wr_i = 1'b0;
  cfd_req_type req_i;
  cfd_cfg_type cfg_o;
  logic [7:0] rd_data_o, q;
  logic rd_valid_o, wr_refused_o, v, r, watchdog_run_o, brownout_run_o, soft_watchdog_en_o;
  logic watchdog_clear_reset_o, boot_seg_wr_ok_o, general_seg_wr_ok_o;
  int miscompares = 0, cmp_count = 0;
  logic [23:0] ofs [7] = '{CFD_OFS_BOOT, CFD_OFS_GEN, CFD_OFS_OSCSEL, CFD_OFS_OSC, CFD_OFS_WDT,
    CFD_OFS_RST, CFD_OFS_DBG};
  logic [7:0] erased [7] = '{8'h0F, 8'h03, 8'hE7, 8'hFF, 8'hFF, 8'hFB, 8'hE3};
  // 125 MHz clock
  always #4 clk_i = ~clk_i;
  cfd_decoder cfd_decoder_inst (.clk_i, .rst_n_i, .req_i, .bulk_erase_i, .hv_entry_i,
    .soft_watchdog_wr_i, .soft_watchdog_val_i, .soft_brownout_en_i, .sleep_i,
    .watchdog_clear_op_i, .watchdog_early_i, .boot_seg_wr_i, .general_seg_wr_i, .rd_data_o,
    .rd_valid_o, .wr_refused_o, .cfg_o, .watchdog_run_o, .brownout_run_o, .soft_watchdog_en_o,
    .watchdog_clear_reset_o, .boot_seg_wr_ok_o, .general_seg_wr_ok_o);
  cfd_host_model cfd_host_model_inst (.clk_i, .req_o(req_i), .rd_data_i(rd_data_o),
    .rd_valid_i(rd_valid_o), .wr_refused_i(wr_refused_o));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] e);
    cfd_host_model_inst.xfer(1'b0, a, 8'h00, 0, q, v, r);
    chk(32'(v), 32'h1);
    chk(32'(q), 32'(e));
  endtask
  // Writes use a slow host, two idle cycles before each request
  task automatic wr(input logic [23:0] a, input logic [7:0] d, input logic e);
    cfd_host_model_inst.xfer(1'b1, a, d, 1, q, v, r);
    chk(32'(r), 32'(e));
  endtask
  // One-cycle strobe; its registered answer is sampled on return
  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Watchdog: the whole run is under a hundred cycles
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
  initial begin
    @(negedge clk_i);
    bulk_erase_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    for (int i = 0; i < 7; i++) rd(ofs[i], erased[i]);
    rd(24'hF80002, 8'h00);
    wr(24'hF80010, 8'h00, 1'b1);
    chk(32'(cfg_o.boot_sec), 32'(CFD_SEC_NONE));
    chk(32'(cfg_o.initial_osc_sel), 32'(CFD_OSC_FRCDIV));
    chk(32'(cfg_o.two_speed_startup_en), 32'h1);
    chk(32'(cfg_o.clock_switch_en), 32'h0);
    chk(32'(cfg_o.clock_output), 32'h1);
    chk(32'(watchdog_run_o), 32'h1);
    chk(32'(cfg_o.watchdog_prescale), 32'(CFD_WDT_PRE_HI));
    chk(32'(cfg_o.watchdog_postscale_sel), 32'hF);
    chk(32'(brownout_run_o), 32'h1);
    chk(32'(cfg_o.debug_pin_pair), 32'h3);
    $display("Test erased bank done");
    wr(CFD_OFS_BOOT, 8'h04, 1'b0);
    wr(CFD_OFS_GEN, 8'h00, 1'b1);
    rd(CFD_OFS_GEN, 8'h03);
    wr(CFD_OFS_OSCSEL, 8'h05, 1'b0);
    wr(CFD_OFS_OSC, 8'h00, 1'b0);
    wr(CFD_OFS_WDT, 8'h10, 1'b0);
    wr(CFD_OFS_RST, 8'h00, 1'b0);
    rd(CFD_OFS_RST, 8'h80);
    wr(CFD_OFS_DBG, 8'h02, 1'b0);
    rd(CFD_OFS_DBG, 8'h62);
    chk(32'(cfg_o.initial_osc_sel), 32'(CFD_OSC_FRCDIV));
    soft_watchdog_val_i = 1'b1;
    pulse(soft_watchdog_wr_i);
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    chk(32'(soft_watchdog_en_o), 32'h0);
    chk(32'(cfg_o.boot_sec), 32'(CFD_SEC_HIGH));
    chk(32'(cfg_o.boot_end), 32'(CFD_BOOT_END_SMALL));
    chk(32'(cfg_o.general_code_protect), 32'h0);
    chk(32'(cfg_o.initial_osc_sel), 32'(CFD_OSC_LOW_POWER_RC_OSC));
    chk(32'(cfg_o.two_speed_startup_en), 32'h0);
    chk(32'(cfg_o.fail_safe_en), 32'h1);
    chk(32'(cfg_o.primary_range_rsvd), 32'h1);
    chk(32'(cfg_o.clock_output), 32'h0);
    chk(32'(cfg_o.watchdog_mode), 32'(CFD_WDT_OFF));
    chk(32'(watchdog_run_o), 32'h0);
    chk(32'(cfg_o.watchdog_postscale_sel), 32'h0);
    chk(32'(cfg_o.ext_reset_pin_en), 32'h1);
    chk(32'(cfg_o.low_power_brownout), 32'h1);
    chk(32'(brownout_run_o), 32'h0);
    chk(32'(cfg_o.debug_en), 32'h1);
    $display("Test programmed bank done");
    pulse(boot_seg_wr_i);
    chk(32'(boot_seg_wr_ok_o), 32'h0);
    pulse(general_seg_wr_i);
    chk(32'(general_seg_wr_ok_o), 32'h1);
    watchdog_early_i = 1'b1;
    pulse(watchdog_clear_op_i);
    chk(32'(watchdog_clear_reset_o), 32'h0);
    pulse(bulk_erase_i);
    rd(CFD_OFS_BOOT, 8'h0F);
    hv_entry_i = 1'b1;
    wr(CFD_OFS_RST, 8'h7F, 1'b0);
    rd(CFD_OFS_RST, 8'h7B);
    wr(CFD_OFS_WDT, 8'hBF, 1'b0);
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    pulse(watchdog_clear_op_i);
    chk(32'(watchdog_clear_reset_o), 32'h1);
    chk(32'(cfg_o.ext_reset_pin_en), 32'h0);
    $display("Test protection and watchdog done");
    stop_test();
  end
endmodule // cfd_decoder_tb
`default_nettype wire
